// ===== src/sysctl_defines.vh
// register map, field positions, reset values and timing constants
`ifndef SYSCTL_DEFINES_VH
`define SYSCTL_DEFINES_VH

// register byte offsets
`define OFS_PART_REVISION_HIGH   8'h00
`define OFS_PART_NUMBER_LOW      8'h04
`define OFS_WAKEUP_CTRL          8'h08
`define OFS_LOW_VOLTAGE_CTRL     8'h0C
`define OFS_IRQ_STATUS           8'h10
`define OFS_IRQ_MASK             8'h14
`define OFS_STOP_CTRL            8'h18

// identity fields (values arbitrary)
`define PART_NUMBER              12'h5_A3
`define MASK_REVISION            4'h1

// wakeup register fields
`define WK_FLAG_BIT              7
`define WK_ACK_BIT               6
`define WK_SRC_BIT               5
`define WK_IE_BIT                4
`define WK_PERIOD_HI             2
`define WK_PERIOD_OFF            3'h0

// low voltage register fields
`define LV_FLAG_BIT              7
`define LV_ACK_BIT               6
`define LV_IE_BIT                5
`define LV_RE_BIT                4
`define LV_SE_BIT                3
`define LV_DE_BIT                2
`define LV_BUF_BIT               0

// irq status / mask bits
`define IRQ_WAKEUP_BIT           0
`define IRQ_LOWV_BIT             1

// stop control bit
`define STOP_MODE_BIT            0

// timing
`define TICK_PERIOD_US           1000
`define TRIM_DIV                 32
`define TRIM_DIV_W               5
`define WK_COUNT_W               10

// last counter value of each period code (ticks minus one)
`define WK_LAST_OFF              10'h000
`define WK_LAST_CODE1            10'h007
`define WK_LAST_CODE2            10'h01F
`define WK_LAST_CODE3            10'h03F
`define WK_LAST_CODE4            10'h07F
`define WK_LAST_CODE5            10'h0FF
`define WK_LAST_CODE6            10'h1FF
`define WK_LAST_CODE7            10'h3FF

// axi responses
`define RESP_OKAY                2'h0
`define RESP_SLVERR              2'h2

`endif

// ===== src/edge_sync.v
// two flop synchroniser with rising edge pulse
`timescale 1ns/1ps
module edge_sync (
  input  wire aclk,
  input  wire aresetn,
  input  wire din,
  output reg  level,
  output reg  rise
);
  reg meta_r;
  reg prev_r;

  always @(posedge aclk) begin
    if (!aresetn) begin
      meta_r <= 1'b0;
      level  <= 1'b0;
      prev_r <= 1'b0;
      rise   <= 1'b0;
    end else begin
      meta_r <= din;
      level  <= meta_r;
      prev_r <= level;
      rise   <= level & ~prev_r;
    end
  end
endmodule

// ===== src/wakeup_timer.v
// periodic wakeup tick selection and timeout counter
`timescale 1ns/1ps
`include "sysctl_defines.vh"
module wakeup_timer (
  input  wire       aclk,
  input  wire       aresetn,
  input  wire       lpo_tick,
  input  wire       trim_tick,
  input  wire       src_sel,
  input  wire [2:0] period_sel,
  output reg        timeout
);
  reg [`TRIM_DIV_W-1:0] div_r;
  reg [`WK_COUNT_W-1:0] cnt_r;
  reg [`WK_COUNT_W-1:0] last;
  wire                  trim_div_tick;
  wire                  tick;

  // trimmed source divided by 32 into a 1 ms tick
  assign trim_div_tick = trim_tick && (div_r == `TRIM_DIV - 1); // [RULE5]
  assign tick = src_sel ? trim_div_tick : lpo_tick; // [RULE5]

  // last count of each period in 1 ms ticks; 1024 ticks still fit the counter
  always @* begin
    case (period_sel) // [RULE7] [RULE8]
      3'h1:    last = `WK_LAST_CODE1;
      3'h2:    last = `WK_LAST_CODE2;
      3'h3:    last = `WK_LAST_CODE3;
      3'h4:    last = `WK_LAST_CODE4;
      3'h5:    last = `WK_LAST_CODE5;
      3'h6:    last = `WK_LAST_CODE6;
      3'h7:    last = `WK_LAST_CODE7;
      default: last = `WK_LAST_OFF;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      div_r   <= {`TRIM_DIV_W{1'b0}};
      cnt_r   <= {`WK_COUNT_W{1'b0}};
      timeout <= 1'b0;
    end else begin
      timeout <= 1'b0;
      if (trim_tick)
        div_r <= div_r + 1'b1;
      if (period_sel == `WK_PERIOD_OFF) begin
        cnt_r <= {`WK_COUNT_W{1'b0}}; // [RULE18]
      end else if (tick) begin
        if (cnt_r >= last) begin
          cnt_r   <= {`WK_COUNT_W{1'b0}}; // [RULE18]
          timeout <= 1'b1;
        end else begin
          cnt_r <= cnt_r + 1'b1;
        end
      end
    end
  end
endmodule

// ===== src/system_id_wakeup_lowvolt_regs.v
// system id, wakeup timer and low voltage register group on axi4-lite
// Overview of operation
// [RULE1] fixed 12-bit part number, upper nibble low
// [RULE2] high nibble is read-only mask revision
// [RULE3] wakeup bit 7 reads timeout flag
// [RULE4] write one bit 6 clears timeout flag
// [RULE5] bit 5 picks 1 kHz or trim/32
// [RULE6] bit 4 enables wakeup interrupt
// [RULE7] period codes 000 off, 8ms to 1.024s
// [RULE8] periods counted in 1 ms ticks
// [RULE9] oscillator off in stop only 000 and src 1
// [RULE10] low voltage flag set only when enabled
// [RULE11] write one bit 6 clears low voltage flag
// [RULE12] bit 5 requests interrupt while flag set
// [RULE13] write-once reset enable forces chip reset
// [RULE14] bit 3 keeps detection alive in stop
// [RULE15] write-once bit 2 enables detect logic
// [RULE16] write-once bits take first write only
// [RULE17] bit 0 powers reference buffer
// [RULE18] counter restarts on match, cleared when off
// [RULE19] wakeup irq while flag and enable set
`timescale 1ns/1ps
`include "sysctl_defines.vh"
module system_id_wakeup_lowvolt_regs (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        lpo_tick_in,
  input  wire        trim_clock_tick_in,
  input  wire        low_voltage_event_in,
  output reg         wakeup_irq,
  output reg         low_voltage_irq,
  output reg         irq,
  output reg         chip_reset_req,
  output reg         lpo_power_down,
  output reg         low_voltage_detector_on,
  output reg         vref_buffer_enable
);
  // ==========================================================
  // register state
  // ==========================================================
  reg        wakeup_timeout_flag_r;
  reg        wakeup_tick_source_sel_r;
  reg        wakeup_irq_enable_r;
  reg [2:0]  wakeup_period_sel_r;
  reg        low_voltage_flag_r;
  reg        low_voltage_irq_enable_r;
  reg        low_voltage_reset_enable_r;
  reg        low_voltage_stop_enable_r;
  reg        low_voltage_detect_enable_r;
  reg        vref_buffer_enable_r;
  reg        once_written_r;
  reg [1:0]  irq_status_r;
  reg [1:0]  irq_mask_r;
  reg        stop_mode_r;
  reg        aw_held_r;
  reg        w_held_r;
  reg [7:0]  awaddr_r;
  reg [31:0] wdata_r;
  reg        wlane0_r;

  wire       lpo_tick;
  wire       trim_tick;
  wire       lv_level;
  wire       lv_rise;
  wire       wakeup_timeout;
  wire       wr_fire;
  wire       lv_active;
  wire       lv_set;
  reg  [7:0] wk_reg;
  reg  [7:0] lv_reg;
  reg  [31:0] rd_mux;
  reg         rd_ok;
  reg         wr_wk;
  reg         wr_lv;
  reg         wr_ist;
  reg         wr_imk;
  reg         wr_stp;
  reg         wr_hit;

  // identity word, fixed at build time
  localparam [11:0] part_number_word = `PART_NUMBER;

  // ==========================================================
  // input synchronisers and timer
  // ==========================================================
  edge_sync u_lpo_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .din     (lpo_tick_in),
    .level   (),
    .rise    (lpo_tick)
  );

  edge_sync u_trim_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .din     (trim_clock_tick_in),
    .level   (),
    .rise    (trim_tick)
  );

  edge_sync u_lv_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .din     (low_voltage_event_in),
    .level   (lv_level),
    .rise    (lv_rise)
  );

  wakeup_timer u_timer (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .lpo_tick   (lpo_tick),
    .trim_tick  (trim_tick),
    .src_sel    (wakeup_tick_source_sel_r),
    .period_sel (wakeup_period_sel_r),
    .timeout    (wakeup_timeout)
  );

  // ==========================================================
  // axi write channel
  // ==========================================================
  assign wr_fire = aw_held_r && w_held_r && !s_axi_bvalid;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r     <= 1'b0;
      w_held_r      <= 1'b0;
      awaddr_r      <= 8'h00;
      wdata_r       <= 32'h0000_0000;
      wlane0_r      <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_held_r && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready  <= !w_held_r && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r     <= 1'b1;
        awaddr_r      <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r     <= 1'b1;
        wdata_r      <= s_axi_wdata;
        wlane0_r     <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        aw_held_r    <= 1'b0;
        w_held_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (wr_hit)
          s_axi_bresp <= `RESP_OKAY;
        else
          s_axi_bresp <= `RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ==========================================================
  // register updates
  // ==========================================================
  wire wr_lane = wr_fire && wlane0_r;

  // write decode on the held address; id words accept and ignore writes
  always @* begin
    wr_wk  = 1'b0;
    wr_lv  = 1'b0;
    wr_ist = 1'b0;
    wr_imk = 1'b0;
    wr_stp = 1'b0;
    wr_hit = 1'b1;
    if (awaddr_r == `OFS_PART_REVISION_HIGH)
      wr_hit = 1'b1; // [RULE2]
    else if (awaddr_r == `OFS_PART_NUMBER_LOW)
      wr_hit = 1'b1;
    else if (awaddr_r == `OFS_WAKEUP_CTRL)
      wr_wk = wr_lane;
    else if (awaddr_r == `OFS_LOW_VOLTAGE_CTRL)
      wr_lv = wr_lane;
    else if (awaddr_r == `OFS_IRQ_STATUS)
      wr_ist = wr_lane;
    else if (awaddr_r == `OFS_IRQ_MASK)
      wr_imk = wr_lane;
    else if (awaddr_r == `OFS_STOP_CTRL)
      wr_stp = wr_lane;
    else
      wr_hit = 1'b0;
  end

  // detection is gated off in stop unless stop enable is set
  assign lv_active = low_voltage_detect_enable_r &&
                     (!stop_mode_r || low_voltage_stop_enable_r); // [RULE14] [RULE15]
  assign lv_set    = lv_active && lv_level; // [RULE10]

  always @(posedge aclk) begin
    if (!aresetn) begin
      wakeup_timeout_flag_r       <= 1'b0;
      wakeup_tick_source_sel_r    <= 1'b0;
      wakeup_irq_enable_r         <= 1'b0;
      wakeup_period_sel_r         <= `WK_PERIOD_OFF;
      low_voltage_flag_r          <= 1'b0;
      low_voltage_irq_enable_r    <= 1'b0;
      low_voltage_reset_enable_r  <= 1'b0;
      low_voltage_stop_enable_r   <= 1'b0;
      low_voltage_detect_enable_r <= 1'b0;
      vref_buffer_enable_r        <= 1'b0;
      once_written_r              <= 1'b0;
      irq_status_r                <= 2'b00;
      irq_mask_r                  <= 2'b00;
      stop_mode_r                 <= 1'b0;
    end else begin
      if (wr_wk) begin
        wakeup_tick_source_sel_r <= wdata_r[`WK_SRC_BIT]; // [RULE5]
        wakeup_irq_enable_r      <= wdata_r[`WK_IE_BIT]; // [RULE6]
        wakeup_period_sel_r      <= wdata_r[`WK_PERIOD_HI:0]; // [RULE7]
      end
      // set wins over acknowledge
      if (wakeup_timeout)
        wakeup_timeout_flag_r <= 1'b1; // [RULE3] [RULE18]
      else if (wr_wk && wdata_r[`WK_ACK_BIT])
        wakeup_timeout_flag_r <= 1'b0; // [RULE4]

      if (wr_lv) begin
        low_voltage_irq_enable_r  <= wdata_r[`LV_IE_BIT]; // [RULE12]
        low_voltage_stop_enable_r <= wdata_r[`LV_SE_BIT]; // [RULE14]
        vref_buffer_enable_r      <= wdata_r[`LV_BUF_BIT]; // [RULE17]
        if (!once_written_r) begin
          once_written_r              <= 1'b1; // [RULE16]
          low_voltage_reset_enable_r  <= wdata_r[`LV_RE_BIT]; // [RULE13]
          low_voltage_detect_enable_r <= wdata_r[`LV_DE_BIT]; // [RULE15]
        end
      end
      if (lv_set)
        low_voltage_flag_r <= 1'b1; // [RULE10]
      else if (wr_lv && wdata_r[`LV_ACK_BIT])
        low_voltage_flag_r <= 1'b0; // [RULE11]

      // sticky status: event beats write-one-to-clear
      irq_status_r[`IRQ_WAKEUP_BIT] <= wakeup_timeout ||
        (irq_status_r[`IRQ_WAKEUP_BIT] && !(wr_ist && wdata_r[`IRQ_WAKEUP_BIT]));
      irq_status_r[`IRQ_LOWV_BIT] <= (lv_set && lv_rise) ||
        (irq_status_r[`IRQ_LOWV_BIT] && !(wr_ist && wdata_r[`IRQ_LOWV_BIT]));
      if (wr_imk)
        irq_mask_r <= wdata_r[1:0];
      if (wr_stp)
        stop_mode_r <= wdata_r[`STOP_MODE_BIT];
    end
  end

  // ==========================================================
  // outputs
  // ==========================================================
  always @(posedge aclk) begin
    if (!aresetn) begin
      wakeup_irq              <= 1'b0;
      low_voltage_irq         <= 1'b0;
      irq                     <= 1'b0;
      chip_reset_req          <= 1'b0;
      lpo_power_down          <= 1'b0;
      low_voltage_detector_on <= 1'b0;
      vref_buffer_enable      <= 1'b0;
    end else begin
      wakeup_irq      <= wakeup_timeout_flag_r && wakeup_irq_enable_r; // [RULE6] [RULE19]
      low_voltage_irq <= low_voltage_flag_r && low_voltage_irq_enable_r &&
                         low_voltage_detect_enable_r; // [RULE12]
      irq             <= |(irq_status_r & irq_mask_r);
      chip_reset_req  <= low_voltage_flag_r && low_voltage_reset_enable_r &&
                         low_voltage_detect_enable_r; // [RULE13]
      lpo_power_down  <= stop_mode_r && (wakeup_period_sel_r == `WK_PERIOD_OFF) &&
                         wakeup_tick_source_sel_r; // [RULE9]
      low_voltage_detector_on <= lv_active; // [RULE14]
      vref_buffer_enable      <= vref_buffer_enable_r; // [RULE17]
    end
  end

  // ==========================================================
  // axi read channel
  // ==========================================================
  always @* begin
    wk_reg = {wakeup_timeout_flag_r, 1'b0, wakeup_tick_source_sel_r,
              wakeup_irq_enable_r, 1'b0, wakeup_period_sel_r}; // [RULE3] [RULE4]
    lv_reg = {low_voltage_flag_r, 1'b0, low_voltage_irq_enable_r,
              low_voltage_reset_enable_r, low_voltage_stop_enable_r,
              low_voltage_detect_enable_r, 1'b0, vref_buffer_enable_r}; // [RULE11]
    rd_mux = 32'h0000_0000;
    rd_ok  = 1'b1;
    if (s_axi_araddr == `OFS_PART_REVISION_HIGH)
      rd_mux = {24'h00_0000, `MASK_REVISION, part_number_word[11:8]}; // [RULE1] [RULE2]
    else if (s_axi_araddr == `OFS_PART_NUMBER_LOW)
      rd_mux = {24'h00_0000, part_number_word[7:0]}; // [RULE1]
    else if (s_axi_araddr == `OFS_WAKEUP_CTRL)
      rd_mux = {24'h00_0000, wk_reg};
    else if (s_axi_araddr == `OFS_LOW_VOLTAGE_CTRL)
      rd_mux = {24'h00_0000, lv_reg};
    else if (s_axi_araddr == `OFS_IRQ_STATUS)
      rd_mux = {30'h0000_0000, irq_status_r};
    else if (s_axi_araddr == `OFS_IRQ_MASK)
      rd_mux = {30'h0000_0000, irq_mask_r};
    else if (s_axi_araddr == `OFS_STOP_CTRL)
      rd_mux = {31'h0000_0000, stop_mode_r};
    else
      rd_ok = 1'b0;
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_mux;
        s_axi_rresp   <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule

// ===== testbench/sysctl_chk.sv
// assertion checker for the system id, wakeup and low voltage register group
`timescale 1ns/1ps
`include "sysctl_defines.vh"
module sysctl_chk (
  input wire        aclk,
  input wire        aresetn,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_bvalid,
  input wire [7:0]  s_axi_araddr,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0]  s_axi_rresp,
  input wire        s_axi_rvalid,
  input wire        wakeup_irq,
  input wire        low_voltage_irq,
  input wire        chip_reset_req,
  input wire        low_voltage_detector_on,
  input wire        vref_buffer_enable
);
  reg [7:0] ra_r;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ==================================================
  // address of the read under way
  always @(posedge aclk) begin
    if (!aresetn)
      ra_r <= 8'h00;
    else if (s_axi_arvalid && s_axi_arready)
      ra_r <= s_axi_araddr;
  end

  sequence ar_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence rd_at(logic [7:0] a);
    $rose(s_axi_rvalid) && ra_r == a;
  endsequence

  // ==================================================
  // bus timing and response codes
  rd_answer_a: assert property (ar_take |=> s_axi_rvalid)
    else $error("read answer missing");
  wr_answer_a: assert property (s_axi_awvalid && s_axi_awready |-> ##[1:8] s_axi_bvalid)
    else $error("write answer missing");
  unmapped_rd_a: assert property ($rose(s_axi_rvalid) && ra_r > 8'h18 |-> s_axi_rresp == `RESP_SLVERR)
    else $error("unmapped read not refused");
  upper_zero_a: assert property ($rose(s_axi_rvalid) |-> s_axi_rdata[31:8] == 24'h00_0000)
    else $error("upper read bits not zero");

  // ==================================================
  // register contents against constants and outputs
  id_high_a: assert property (rd_at(8'h00) |-> s_axi_rdata[7:0] == ((`MASK_REVISION << 4) | (`PART_NUMBER >> 8)))
    else $error("high id value wrong");
  id_low_a: assert property (rd_at(8'h04) |-> s_axi_rdata[7:0] == (`PART_NUMBER & 12'h0FF))
    else $error("low id value wrong");
  ack_zero_a: assert property (rd_at(8'h08) or rd_at(8'h0C) |-> !s_axi_rdata[6])
    else $error("acknowledge bit read as one");
  wk_irq_a: assert property (rd_at(8'h08) ##0 (s_axi_rdata[7] && s_axi_rdata[4]) |-> ##[0:1] wakeup_irq)
    else $error("wakeup irq missing");
  lv_gate_a: assert property (rd_at(8'h0C) ##0 !s_axi_rdata[2] |->
    !s_axi_rdata[7] && !low_voltage_irq && !chip_reset_req && !low_voltage_detector_on)
    else $error("low voltage active while disabled");
  lv_reset_a: assert property (rd_at(8'h0C) ##0 (s_axi_rdata[7] && s_axi_rdata[4]) |-> ##[0:1] chip_reset_req)
    else $error("chip reset request missing");
  lv_irq_a: assert property (rd_at(8'h0C) ##0 (s_axi_rdata[7] && s_axi_rdata[5]) |-> ##[0:1] low_voltage_irq)
    else $error("low voltage irq missing");
  vref_a: assert property (rd_at(8'h0C) |-> vref_buffer_enable == s_axi_rdata[0])
    else $error("reference buffer enable wrong");
endmodule

bind system_id_wakeup_lowvolt_regs sysctl_chk sysctl_chk_i (.*);

// ===== testbench/tb_system_id_wakeup_lowvolt_regs.sv
// self-checking bench for the system id, wakeup and low voltage register group
`timescale 1ns/1ps
`include "sysctl_defines.vh"
module tb_system_id_wakeup_lowvolt_regs;
  logic        aclk, aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, rd, idh;
  logic [3:0]  s_axi_wstrb = 4'h0, ph = 4'h0;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0, lpo_tick_in = 1'b0, trim_clock_tick_in = 1'b0, low_voltage_event_in = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, tick_en = 1'b0, tick_src = 1'b0;
  logic        wakeup_irq, low_voltage_irq, irq, chip_reset_req, lpo_power_down, low_voltage_detector_on;
  logic        vref_buffer_enable;
  int          edges = 0, err_count = 0, checks = 0;
  int          ticks [1:8] = '{8, 32, 64, 128, 256, 512, 1024, `TRIM_DIV * 8};

  system_id_wakeup_lowvolt_regs system_id_wakeup_lowvolt_regs_i (.*);

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // ==================================================
  // tick sources, one rising edge every 16 clocks while enabled
  always @(posedge aclk) begin
    ph <= ph + 4'h1;
    lpo_tick_in <= tick_en && !tick_src && ph[3];
    trim_clock_tick_in <= tick_en && tick_src && ph[3];
    if (!tick_en)
      edges <= 0;
    else if (ph[3] && !(tick_src ? trim_clock_tick_in : lpo_tick_in))
      edges <= edges + 1;
  end

  // ==================================================
  // bus tasks and comparison
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!(s_axi_bvalid && s_axi_bready));
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd_word(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!(s_axi_rvalid && s_axi_rready));
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    rd_word(a);
    chk("rdata", rd, e);
    chk("rresp", rsp, `RESP_OKAY);
  endtask

  task automatic wait_hi(input int w);
    int k;
    k = 0;
    while (!(w ? low_voltage_irq : wakeup_irq) && k < 20000) begin
      @(posedge aclk);
      k++;
    end
    if (k >= 20000)
      err_count++;
  endtask

  task automatic do_reset();
    aresetn <= 1'b0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
  endtask

  task automatic test_done();
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // ==================================================
  // test sequence
  initial begin
    do_reset();
    idh = (32'(`MASK_REVISION) << 4) | (32'(`PART_NUMBER) >> 8);
    rdc(`OFS_PART_REVISION_HIGH, idh);
    wr(`OFS_PART_REVISION_HIGH, 32'h0000_00FF, 4'hF);
    rdc(`OFS_PART_REVISION_HIGH, idh);
    rdc(`OFS_PART_NUMBER_LOW, 32'(`PART_NUMBER) & 32'h0000_00FF);
    rd_word(8'h1C);
    chk("rresp", rsp, `RESP_SLVERR);
    chk("rdata", rd, 32'h0000_0000);
    wr(8'h1C, 32'h0000_00FF, 4'hF);
    chk("bresp", rsp, `RESP_SLVERR);
    // detection left off, then locked off
    wr(`OFS_LOW_VOLTAGE_CTRL, 32'h0000_0020, 4'h1);
    low_voltage_event_in <= 1'b1;
    repeat (10) @(posedge aclk);
    rdc(`OFS_LOW_VOLTAGE_CTRL, 32'h0000_0020);
    wr(`OFS_LOW_VOLTAGE_CTRL, 32'h0000_0034, 4'h1);
    rdc(`OFS_LOW_VOLTAGE_CTRL, 32'h0000_0020);
    chk("lv_irq", low_voltage_irq, 1'b0);
    chk("reset_req", chip_reset_req, 1'b0);
    low_voltage_event_in <= 1'b0;
    do_reset();
    // detection on with irq, reset and buffer
    wr(`OFS_LOW_VOLTAGE_CTRL, 32'h0000_0035, 4'h1);
    repeat (2) @(posedge aclk);
    chk("vref", vref_buffer_enable, 1'b1);
    chk("det_on", low_voltage_detector_on, 1'b1);
    low_voltage_event_in <= 1'b1;
    wait_hi(1);
    chk("lv_irq", low_voltage_irq, 1'b1);
    chk("reset_req", chip_reset_req, 1'b1);
    rdc(`OFS_LOW_VOLTAGE_CTRL, 32'h0000_00B5);
    rdc(`OFS_IRQ_STATUS, 32'h0000_0002);
    low_voltage_event_in <= 1'b0;
    repeat (8) @(posedge aclk);
    wr(`OFS_LOW_VOLTAGE_CTRL, 32'h0000_0060, 4'h1);
    rdc(`OFS_LOW_VOLTAGE_CTRL, 32'h0000_0034);
    chk("lv_irq", low_voltage_irq, 1'b0);
    chk("vref", vref_buffer_enable, 1'b0);
    // stop mode effects
    wr(`OFS_STOP_CTRL, 32'h0000_0001, 4'h1);
    repeat (2) @(posedge aclk);
    chk("det_on", low_voltage_detector_on, 1'b0);
    wr(`OFS_LOW_VOLTAGE_CTRL, 32'h0000_0028, 4'h1);
    rdc(`OFS_LOW_VOLTAGE_CTRL, 32'h0000_003C);
    chk("det_on", low_voltage_detector_on, 1'b1);
    wr(`OFS_WAKEUP_CTRL, 32'h0000_0020, 4'h1);
    repeat (2) @(posedge aclk);
    chk("lpo_pd", lpo_power_down, 1'b1);
    wr(`OFS_WAKEUP_CTRL, 32'h0000_0021, 4'h1);
    repeat (2) @(posedge aclk);
    chk("lpo_pd", lpo_power_down, 1'b0);
    wr(`OFS_STOP_CTRL, 32'h0000_0000, 4'h1);
    wr(`OFS_WAKEUP_CTRL, 32'h0000_0013, 4'h0);
    rdc(`OFS_WAKEUP_CTRL, 32'h0000_0021);
    // period codes 1 to 7 on the 1 kHz source, then code 1 on the trimmed source
    for (int i = 1; i < 9; i++) begin
      wr(`OFS_WAKEUP_CTRL, 32'h0000_0050 | (i == 8 ? 32'h0000_0021 : i), 4'h1);
      repeat (2) @(posedge aclk);
      tick_src <= (i == 8);
      tick_en <= 1'b1;
      wait_hi(0);
      tick_en <= 1'b0;
      chk("ticks", edges, ticks[i]);
      rdc(`OFS_WAKEUP_CTRL, 32'h0000_0090 | (i == 8 ? 32'h0000_0021 : i));
    end
    wr(`OFS_WAKEUP_CTRL, 32'h0000_0021, 4'h1);
    repeat (2) @(posedge aclk);
    chk("wk_irq", wakeup_irq, 1'b0);
    chk("irq", irq, 1'b0);
    wr(`OFS_IRQ_MASK, 32'h0000_0001, 4'h1);
    repeat (2) @(posedge aclk);
    chk("irq", irq, 1'b1);
    wr(`OFS_IRQ_STATUS, 32'h0000_0003, 4'h1);
    repeat (2) @(posedge aclk);
    chk("irq", irq, 1'b0);
    rdc(`OFS_IRQ_STATUS, 32'h0000_0000);
    rdc(`OFS_IRQ_MASK, 32'h0000_0001);
    wr(`OFS_WAKEUP_CTRL, 32'h0000_0011, 4'h1);
    repeat (2) @(posedge aclk);
    chk("wk_irq", wakeup_irq, 1'b1);
    wr(`OFS_WAKEUP_CTRL, 32'h0000_0051, 4'h1);
    repeat (2) @(posedge aclk);
    chk("wk_irq", wakeup_irq, 1'b0);
    rdc(`OFS_WAKEUP_CTRL, 32'h0000_0011);
    test_done();
  end

  initial begin
    repeat (80000) @(posedge aclk);
    err_count++;
    test_done();
  end
endmodule
